/* File: verilog/lin_ctrl_pkg.sv */
// Constants, register map and shared types of the LIN protocol controller.
package lin_ctrl_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int unsigned IDLE_S_0 = 4;
	localparam int unsigned IDLE_S_1 = 6;
	localparam int unsigned IDLE_S_2 = 8;
	localparam int unsigned IDLE_S_3 = 10;
	localparam logic [7:0] WAKE_MS_0 = 8'hB4;
	localparam logic [7:0] WAKE_MS_1 = 8'hC8;
	localparam logic [7:0] WAKE_MS_2 = 8'hDC;
	localparam logic [7:0] WAKE_MS_3 = 8'hF0;
	localparam logic [7:0] WAKE_PULSE_MS = 8'h01;
	localparam logic [20:0] BRK_DETECT_BITS = 21'h0_000B;
	localparam logic [20:0] BRK_SEND_BITS = 21'h0_000D;
	localparam logic [2:0] SYNC_EDGES = 3'h4;
	localparam logic [7:0] SYNC_BYTE = 8'h55;
	localparam logic [3:0] LEN_FROM_ID = 4'hF;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	localparam logic [3:0] STOP_BIT_IDX = 4'h9;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] OFF_CTRL = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'h9;
	localparam logic [3:0] OFF_ERROR = 4'hA;
	localparam logic [3:0] OFF_LENGTH = 4'hB;
	localparam logic [3:0] OFF_DIV_LO = 4'hC;
	localparam logic [3:0] OFF_TIMING = 4'hD;
	localparam logic [3:0] OFF_ID = 4'hE;
	localparam logic [3:0] OFF_BUS_TIMING = 4'hF;

	// ==========================================================
	// Field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_SEND_WAKE = 1;
	localparam int CTRL_CLR_IRQ = 2;
	localparam int CTRL_CLR_FAULT = 3;
	localparam int CTRL_RESP_READY = 4;
	localparam int CTRL_TRANSMIT = 5;
	localparam int CTRL_SLEEP = 6;
	localparam int CTRL_STOP = 7;
	localparam int LEN_KIND = 7;
	localparam int TIM_DIV_MSB = 0;
	localparam int TIM_MASTER = 1;
	localparam int TIM_PRESC_LSB = 2;
	localparam int TIM_MUL_LSB = 4;
	localparam int IDLE_SEL_LSB = 0;
	localparam int WAKE_SEL_LSB = 2;

	// ==========================================================
	// Reset values
	localparam logic [8:0] BIT_TIME_DIVIDER_RST = 9'h0C8;
	localparam logic [1:0] PRESC_RST = 2'h0;
	localparam logic [3:0] MUL_RST = 4'h0;
	localparam logic [3:0] LEN_RST = 4'h0;
	localparam logic [7:0] ID_RST = 8'h00;
	localparam logic [1:0] SEL_RST = 2'h0;

	// ==========================================================
	// Types
	typedef struct packed {
		logic header_rx;
		logic idle_exp;
		logic wakeup;
		logic complete;
	} flags_t;

	typedef struct packed {
		logic framing;
		logic timeout;
		logic checksum;
		logic mismatch;
	} err_t;

endpackage : lin_ctrl_pkg

/* File: verilog/lin_protocol_controller.sv */
// LIN data-link controller: header, response, checksum, sleep and wakeup.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps

module lin_protocol_controller #(
	parameter int unsigned MS_CYCLES = lin_ctrl_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic rxd,
	output logic txd,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic irq
);

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_BRK = 4'h1,
		ST_SYNC = 4'h3,
		ST_ID = 4'h2,
		ST_WACK = 4'h6,
		ST_RESP = 4'h7,
		ST_IGNORE = 4'h5,
		ST_MBRK = 4'h4,
		ST_MDEL = 4'hC,
		ST_MSYNC = 4'hD,
		ST_WTX = 4'hF,
		ST_WWAIT = 4'hE
	} state_t;

	// ==========================================================
	// Functions
	function automatic logic [7:0] add_c(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction : add_c

	function automatic logic [7:0] pid_of(input logic [5:0] id);
		logic p0;
		logic p1;
		p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
		p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
		return {p1, p0, id};
	endfunction : pid_of

	function automatic logic [3:0] resp_len(input logic [3:0] len,
		input logic [1:0] id54);
		if (len == lin_ctrl_pkg::LEN_FROM_ID) begin
			if (id54 == 2'h3) begin
				return 4'h8;
			end else if (id54 == 2'h2) begin
				return 4'h4;
			end else begin
				return 4'h2;
			end
		end else if (len > lin_ctrl_pkg::MAX_BYTES) begin
			return lin_ctrl_pkg::MAX_BYTES;
		end else begin
			return len;
		end
	endfunction : resp_len

	function automatic logic [13:0] idle_lim(input logic [1:0] sel);
		int unsigned s;
		case (sel)
			2'h0: s = lin_ctrl_pkg::IDLE_S_0;
			2'h1: s = lin_ctrl_pkg::IDLE_S_1;
			2'h2: s = lin_ctrl_pkg::IDLE_S_2;
			default: s = lin_ctrl_pkg::IDLE_S_3;
		endcase
		return 14'(s * lin_ctrl_pkg::MS_PER_S);
	endfunction : idle_lim

	function automatic logic [7:0] wake_lim(input logic [1:0] sel);
		case (sel)
			2'h0: return lin_ctrl_pkg::WAKE_MS_0;
			2'h1: return lin_ctrl_pkg::WAKE_MS_1;
			2'h2: return lin_ctrl_pkg::WAKE_MS_2;
			default: return lin_ctrl_pkg::WAKE_MS_3;
		endcase
	endfunction : wake_lim

	// ==========================================================
	// State
	logic [7:0] buf_q [8];
	logic [8:0] bit_time_divider_q;
	logic [1:0] presc_q;
	logic [3:0] mul_q;
	logic master_q;
	logic [3:0] len_q;
	logic kind_q;
	logic [7:0] id_q;
	logic [1:0] idle_sel_q;
	logic [1:0] wake_sel_q;
	logic transmit_q;
	logic sleep_q;
	lin_ctrl_pkg::flags_t flg_q;
	lin_ctrl_pkg::err_t err_q;
	logic irq_q;
	state_t st_q;
	logic rxd_m_q;
	logic rxd_s_q;
	logic rxd_p_q;
	logic [2:0] pre_cnt_q;
	logic [16:0] ms_cnt_q;
	logic [13:0] idle_ms_q;
	logic [7:0] wk_ms_q;
	logic [20:0] dom_cnt_q;
	logic [20:0] tcnt_q;
	logic [2:0] nf_q;
	logic [16:0] meas_q;
	logic meas_ok_q;
	logic bon_q;
	logic [3:0] bidx_q;
	logic [9:0] sh_q;
	logic [7:0] rx_q;
	logic [3:0] bi_q;
	logic [7:0] chk_q;
	logic [7:0] rdata_q;
	logic txd_q;
	logic [7:0] rd_mux;

	// ==========================================================
	// Register decode
	wire we = wr & ce;
	wire wr_ctrl = we && addr == lin_ctrl_pkg::OFF_CTRL;
	wire start_req = wr_ctrl & wdata[lin_ctrl_pkg::CTRL_START];
	wire wake_req = wr_ctrl & wdata[lin_ctrl_pkg::CTRL_SEND_WAKE];
	wire clr_irq = wr_ctrl & wdata[lin_ctrl_pkg::CTRL_CLR_IRQ];
	wire clr_fault = wr_ctrl & wdata[lin_ctrl_pkg::CTRL_CLR_FAULT];
	wire resp_ready = wr_ctrl & wdata[lin_ctrl_pkg::CTRL_RESP_READY];
	wire stop_req = wr_ctrl & wdata[lin_ctrl_pkg::CTRL_STOP];
	wire wr_buf = we && addr < lin_ctrl_pkg::OFF_CTRL;
	wire wr_id = we && addr == lin_ctrl_pkg::OFF_ID;
	wire error = |err_q;

	// ==========================================================
	// Bit timing
	wire [2:0] pre_max = 3'((4'h1 << presc_q) - 4'h1);
	wire pre_tick = ce && pre_cnt_q == pre_max;
	wire [16:0] m_bt = {8'h00, bit_time_divider_q} * ({13'h0000, mul_q} + 17'h0_0001);
	wire [16:0] s_bt = meas_ok_q ? meas_q : {8'h00, bit_time_divider_q};
	wire [16:0] bt = master_q ? m_bt : s_bt;
	wire [20:0] bt_w = {4'h0, bt};
	wire [20:0] half = {5'h00, bt[16:1]};
	wire [20:0] bt_m1 = bt_w - 21'h0_0001;
	wire [20:0] brk_thr = bt_w * lin_ctrl_pkg::BRK_DETECT_BITS;
	wire [20:0] brk_len = bt_w * lin_ctrl_pkg::BRK_SEND_BITS;
	wire [16:0] ms_m1 = 17'(MS_CYCLES - 1);
	wire ms_tick = ce && ms_cnt_q == ms_m1;

	// ==========================================================
	// Bus events
	wire fall = ce & rxd_p_q & ~rxd_s_q;
	wire rise = ce & ~rxd_p_q & rxd_s_q;
	wire wk_st = st_q == ST_WTX || st_q == ST_WWAIT;
	wire brk_ok = !master_q && !sleep_q && !wk_st && st_q != ST_BRK &&
		st_q != ST_SYNC;
	wire brk_hit = pre_tick && !rxd_s_q && dom_cnt_q == brk_thr && brk_ok;
	wire byte_st = st_q == ST_MSYNC || st_q == ST_ID || st_q == ST_RESP;
	wire btx = st_q == ST_MSYNC || (st_q == ST_ID && master_q) ||
		(st_q == ST_RESP && transmit_q);
	wire samp = bon_q && pre_tick && tcnt_q == half;
	wire tend = bon_q && pre_tick && tcnt_q == bt_m1;
	wire last_bit = bidx_q == lin_ctrl_pkg::STOP_BIT_IDX;
	wire byte_done = last_bit && (btx ? tend : samp);
	wire [3:0] n_bytes = resp_len(len_q, id_q[5:4]);
	wire [7:0] pid = master_q ? pid_of(id_q[5:0]) : id_q;
	wire last_byte = bi_q == n_bytes;
	wire [7:0] tx_byte = st_q == ST_MSYNC ? lin_ctrl_pkg::SYNC_BYTE :
		st_q == ST_ID ? pid : !last_byte ? buf_q[bi_q[2:0]] : ~chk_q;
	wire [7:0] cur_byte = btx ? tx_byte : rx_q;

	wire ev_hdr = st_q == ST_ID && byte_done;
	wire ev_resp = st_q == ST_RESP && byte_done && last_byte;
	wire ev_chk_err = ev_resp && !transmit_q && rx_q != ~chk_q;
	wire ev_done = ev_resp && !ev_chk_err;
	wire ev_mism = samp && btx && rxd_s_q != sh_q[bidx_q];
	wire ev_frame = samp && !btx && last_bit && !rxd_s_q;
	wire ev_noack = st_q == ST_WACK && fall && !resp_ready && !stop_req;
	wire ev_idle = ce && !sleep_q && idle_ms_q == idle_lim(idle_sel_q);
	wire ev_wk_rx = sleep_q && rise && !wk_st && dom_cnt_q >= bt_w;
	wire wk_pulse_end = st_q == ST_WTX &&
		wk_ms_q == lin_ctrl_pkg::WAKE_PULSE_MS + 8'h01;
	wire ev_wk_ok_m = wk_pulse_end && master_q;
	wire ev_wk_to = ce && st_q == ST_WWAIT &&
		wk_ms_q == wake_lim(wake_sel_q);
	wire abort = ev_mism | ev_frame | ev_idle | ev_chk_err;
	wire ev_any = ev_hdr | ev_done | ev_chk_err | ev_mism | ev_frame |
		ev_noack | ev_idle | ev_wk_rx | ev_wk_ok_m | ev_wk_to;

	// ==========================================================
	// Pin sampling and counters
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
			rxd_p_q <= 1'b1;
			txd_q <= 1'b1;
		end else if (ce) begin
			rxd_m_q <= rxd;
			rxd_s_q <= rxd_m_q;
			rxd_p_q <= rxd_s_q;
			txd_q <= (bon_q && btx) ? sh_q[bidx_q] :
				!(st_q == ST_MBRK || st_q == ST_WTX);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_cnt_q <= 3'h0;
			ms_cnt_q <= 17'h0_0000;
			dom_cnt_q <= 21'h0_0000;
		end else if (ce) begin
			pre_cnt_q <= pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
			ms_cnt_q <= ms_tick ? 17'h0_0000 : ms_cnt_q + 17'h0_0001;
			if (rxd_s_q) begin
				dom_cnt_q <= 21'h0_0000;
			end else if (pre_tick && dom_cnt_q != 21'h1F_FFFF) begin
				dom_cnt_q <= dom_cnt_q + 21'h0_0001;
			end
		end
	end

	// Any edge on the bus counts as activity; sleep holds the count at zero.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idle_ms_q <= 14'h0000;
			wk_ms_q <= 8'h00;
		end else if (ce) begin
			if (fall || rise || sleep_q) begin
				idle_ms_q <= 14'h0000;
			end else if (ms_tick && !ev_idle) begin
				idle_ms_q <= idle_ms_q + 14'h0001;
			end
			if (!wk_st || wk_pulse_end) begin
				wk_ms_q <= 8'h00;
			end else if (ms_tick) begin
				wk_ms_q <= wk_ms_q + 8'h01;
			end
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_time_divider_q <= lin_ctrl_pkg::BIT_TIME_DIVIDER_RST;
			presc_q <= lin_ctrl_pkg::PRESC_RST;
			mul_q <= lin_ctrl_pkg::MUL_RST;
			master_q <= 1'b0;
			len_q <= lin_ctrl_pkg::LEN_RST;
			kind_q <= 1'b0;
			idle_sel_q <= lin_ctrl_pkg::SEL_RST;
			wake_sel_q <= lin_ctrl_pkg::SEL_RST;
			transmit_q <= 1'b0;
		end else if (we) begin
			if (addr == lin_ctrl_pkg::OFF_DIV_LO) begin
				bit_time_divider_q[7:0] <= wdata;
			end else if (addr == lin_ctrl_pkg::OFF_TIMING) begin
				bit_time_divider_q[8] <= wdata[lin_ctrl_pkg::TIM_DIV_MSB];
				master_q <= wdata[lin_ctrl_pkg::TIM_MASTER];
				presc_q <= wdata[lin_ctrl_pkg::TIM_PRESC_LSB +: 2];
				mul_q <= wdata[lin_ctrl_pkg::TIM_MUL_LSB +: 4];
			end else if (addr == lin_ctrl_pkg::OFF_LENGTH) begin
				len_q <= wdata[3:0];
				kind_q <= wdata[lin_ctrl_pkg::LEN_KIND];
			end else if (addr == lin_ctrl_pkg::OFF_BUS_TIMING) begin
				idle_sel_q <= wdata[lin_ctrl_pkg::IDLE_SEL_LSB +: 2];
				wake_sel_q <= wdata[lin_ctrl_pkg::WAKE_SEL_LSB +: 2];
			end else if (addr == lin_ctrl_pkg::OFF_CTRL) begin
				transmit_q <= wdata[lin_ctrl_pkg::CTRL_TRANSMIT];
			end
		end
	end

	// ==========================================================
	// Flags: a hardware set always wins over a software clear.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sleep_q <= 1'b0;
			flg_q <= '0;
			err_q <= '0;
			irq_q <= 1'b0;
		end else if (ce) begin
			if (ev_idle) begin
				sleep_q <= 1'b1;
			end else if (wr_ctrl) begin
				sleep_q <= wdata[lin_ctrl_pkg::CTRL_SLEEP];
			end
			flg_q.header_rx <= (flg_q.header_rx & ~clr_irq) | ev_hdr;
			flg_q.idle_exp <= (flg_q.idle_exp & ~clr_irq) | ev_idle;
			flg_q.wakeup <= (flg_q.wakeup & ~clr_irq) | ev_wk_rx |
				ev_wk_ok_m | ev_wk_to;
			flg_q.complete <= (flg_q.complete & ~clr_irq) | ev_done;
			err_q.mismatch <= (err_q.mismatch & ~clr_fault) | ev_mism;
			err_q.checksum <= (err_q.checksum & ~clr_fault) | ev_chk_err;
			err_q.timeout <= (err_q.timeout & ~clr_fault) | ev_noack |
				ev_wk_to;
			err_q.framing <= (err_q.framing & ~clr_fault) | ev_frame;
			irq_q <= (irq_q & ~clr_irq) | ev_any;
		end
	end

	// ==========================================================
	// Frame sequencer and byte engine
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			tcnt_q <= 21'h0_0000;
			nf_q <= 3'h0;
			meas_q <= 17'h0_0000;
			meas_ok_q <= 1'b0;
			bon_q <= 1'b0;
			bidx_q <= 4'h0;
			sh_q <= 10'h3FF;
			rx_q <= 8'h00;
			bi_q <= 4'h0;
			chk_q <= 8'h00;
			id_q <= lin_ctrl_pkg::ID_RST;
			for (int i = 0; i < 8; i++) begin
				buf_q[i] <= 8'h00;
			end
		end else if (ce) begin
			if (wr_buf) begin
				buf_q[addr[2:0]] <= wdata;
			end
			if (wr_id) begin
				id_q <= wdata;
			end
			if (abort || ev_wk_to) begin
				st_q <= ST_IDLE;
				bon_q <= 1'b0;
			end else if (brk_hit) begin
				st_q <= ST_BRK;
				bon_q <= 1'b0;
			end else begin
				if (byte_st) begin
					if (!bon_q) begin
						if (btx || fall) begin
							bon_q <= 1'b1;
							bidx_q <= 4'h0;
							tcnt_q <= 21'h0_0000;
							sh_q <= {1'b1, tx_byte, 1'b0};
						end
					end else if (pre_tick) begin
						if (samp && bidx_q != 4'h0 && !last_bit) begin
							rx_q <= {rxd_s_q, rx_q[7:1]};
						end
						if (byte_done) begin
							bon_q <= 1'b0;
						end else if (tend) begin
							tcnt_q <= 21'h0_0000;
							bidx_q <= bidx_q + 4'h1;
						end else begin
							tcnt_q <= tcnt_q + 21'h0_0001;
						end
					end
				end
				case (st_q)
					ST_IDLE: begin
						if (start_req && master_q && !error && !sleep_q) begin
							st_q <= ST_MBRK;
							tcnt_q <= 21'h0_0000;
						end else if (wake_req && !error) begin
							st_q <= ST_WTX;
						end
					end
					ST_BRK: begin
						if (rxd_s_q) begin
							st_q <= ST_SYNC;
							nf_q <= 3'h0;
							tcnt_q <= 21'h0_0000;
						end
					end
					ST_SYNC: begin
						if (fall) begin
							if (nf_q == 3'h0) begin
								tcnt_q <= 21'h0_0000;
								nf_q <= 3'h1;
							end else if (nf_q == lin_ctrl_pkg::SYNC_EDGES) begin
								// Five falling edges span eight bit times.
								meas_q <= tcnt_q[19:3];
								meas_ok_q <= 1'b1;
								st_q <= ST_ID;
								bon_q <= 1'b0;
							end else begin
								nf_q <= nf_q + 3'h1;
							end
						end else if (pre_tick && nf_q != 3'h0) begin
							tcnt_q <= tcnt_q + 21'h0_0001;
						end
					end
					ST_MBRK: begin
						if (pre_tick) begin
							if (tcnt_q == brk_len) begin
								st_q <= ST_MDEL;
								tcnt_q <= 21'h0_0000;
							end else begin
								tcnt_q <= tcnt_q + 21'h0_0001;
							end
						end
					end
					ST_MDEL: begin
						if (pre_tick) begin
							if (tcnt_q == bt_w) begin
								st_q <= ST_MSYNC;
								bon_q <= 1'b0;
							end else begin
								tcnt_q <= tcnt_q + 21'h0_0001;
							end
						end
					end
					ST_MSYNC: begin
						if (byte_done) begin
							st_q <= ST_ID;
						end
					end
					ST_ID: begin
						if (byte_done) begin
							st_q <= ST_WACK;
							if (!master_q) begin
								id_q <= rx_q;
							end
						end
					end
					ST_WACK: begin
						if (resp_ready) begin
							st_q <= ST_RESP;
							bi_q <= 4'h0;
							bon_q <= 1'b0;
							chk_q <= kind_q ? pid : 8'h00;
						end else if (stop_req) begin
							st_q <= ST_IGNORE;
						end else if (ev_noack) begin
							st_q <= ST_IGNORE;
						end
					end
					ST_RESP: begin
						if (byte_done) begin
							if (last_byte) begin
								st_q <= ST_IDLE;
							end else begin
								chk_q <= add_c(chk_q, cur_byte);
								if (!transmit_q) begin
									buf_q[bi_q[2:0]] <= rx_q;
								end
								bi_q <= bi_q + 4'h1;
							end
						end
					end
					ST_WTX: begin
						if (wk_pulse_end) begin
							st_q <= master_q ? ST_IDLE : ST_WWAIT;
						end
					end
					ST_WWAIT: begin
						if (fall) begin
							st_q <= ST_IDLE;
						end
					end
					default: begin
						st_q <= st_q;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Read port
	always_comb begin
		if (addr < lin_ctrl_pkg::OFF_CTRL) begin
			rd_mux = buf_q[addr[2:0]];
		end else if (addr == lin_ctrl_pkg::OFF_CTRL) begin
			rd_mux = {1'b0, sleep_q, transmit_q, 5'h00};
		end else if (addr == lin_ctrl_pkg::OFF_STATUS) begin
			rd_mux = {sleep_q, st_q != ST_IDLE, flg_q.header_rx,
				flg_q.idle_exp, irq_q, error, flg_q.wakeup, flg_q.complete};
		end else if (addr == lin_ctrl_pkg::OFF_ERROR) begin
			rd_mux = {4'h0, err_q};
		end else if (addr == lin_ctrl_pkg::OFF_LENGTH) begin
			rd_mux = {kind_q, 3'h0, len_q};
		end else if (addr == lin_ctrl_pkg::OFF_DIV_LO) begin
			rd_mux = bit_time_divider_q[7:0];
		end else if (addr == lin_ctrl_pkg::OFF_TIMING) begin
			rd_mux = {mul_q, presc_q, master_q, bit_time_divider_q[8]};
		end else if (addr == lin_ctrl_pkg::OFF_ID) begin
			rd_mux = id_q;
		end else begin
			rd_mux = {4'h0, wake_sel_q, idle_sel_q};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= rd ? rd_mux : 8'h00;
		end
	end

	assign rdata = rdata_q;
	assign txd = txd_q;
	assign irq = irq_q;

endmodule : lin_protocol_controller

/* File: verif/lin_ctrl_props.sv */
// Port-level assertions for the LIN protocol controller.
`timescale 1ns/10ps

module lin_ctrl_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic rxd,
	input wire logic txd,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq
);
	logic rd_go;
	logic wr_go;
	logic clr_go;
	assign rd_go = rd && ce;
	assign wr_go = wr && ce;
	assign clr_go = wr_go && addr == lin_ctrl_pkg::OFF_CTRL &&
		wdata[lin_ctrl_pkg::CTRL_CLR_IRQ];
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// ==========================================================
	// Assertions
	a_reset_outs: assert property ($fell(rst) |-> txd && !irq && !rdata)
		else $error("outputs left reset state");
	a_rdata_idle: assert property (!$past(rd_go) && $past(ce) |-> rdata == 8'h00)
		else $error("read data outside its slot");
	a_ctrl_fmt: assert property (
		rd_go && addr == lin_ctrl_pkg::OFF_CTRL |=> (rdata & 8'h9F) == 8'h00)
		else $error("control read shows strobe bits");
	a_err_fmt: assert property (
		rd_go && addr == lin_ctrl_pkg::OFF_ERROR |=> rdata[7:4] == 4'h0)
		else $error("error read has stray bits");
	a_status_irq: assert property (
		rd_go && addr == lin_ctrl_pkg::OFF_STATUS |=> rdata[3] == $past(irq))
		else $error("status irq bit differs from irq");
	a_sel_back: assert property (
		wr_go && addr == lin_ctrl_pkg::OFF_BUS_TIMING ##2
		rd_go && addr == lin_ctrl_pkg::OFF_BUS_TIMING
		|=> rdata[3:0] == $past(wdata[3:0], 3))
		else $error("timing select not read back");
	a_irq_sticky: assert property (irq && !clr_go |=> irq)
		else $error("irq dropped without clear");
	a_clear_irq: assert property (clr_go |-> ##[1:2] !irq)
		else $error("irq kept after clear");
	a_freeze: assert property (
		!ce |=> $stable(txd) && $stable(irq) && $stable(rdata))
		else $error("outputs moved while disabled");

	c_irq: cover property ($rose(irq));
	c_freeze: cover property (!ce ##1 ce);
	c_done: cover property (rd_go && addr == lin_ctrl_pkg::OFF_STATUS ##1 rdata[0]);
endmodule : lin_ctrl_props

bind lin_protocol_controller lin_ctrl_props lin_ctrl_props_i (
	.ref_clk(ref_clk), .rst(rst), .ce(ce), .rxd(rxd), .txd(txd),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq)
);

/* File: verif/lin_node_model.sv */
// Behavioural master node that drives the shared LIN line.
`timescale 1ns/10ps

module lin_node_model #(
	parameter int BIT_CYC = 100
) (
	input wire logic ref_clk,
	output logic tx
);
	initial tx = 1'b1;

	task automatic hold(input logic lvl, input int bits);
		tx <= lvl;
		repeat (bits * BIT_CYC) @(posedge ref_clk);
	endtask : hold

	task automatic send(input logic [7:0] b);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			hold(b[i], 1);
		end
		hold(1'b1, 1);
	endtask : send

	// The break outlasts eleven bit times so a slave at the same bit rate sees it.
	task automatic header(input logic [7:0] pid);
		hold(1'b0, 13);
		hold(1'b1, 1);
		send(lin_ctrl_pkg::SYNC_BYTE);
		send(pid);
	endtask : header
endmodule : lin_node_model

/* File: verif/lin_protocol_controller_tb.sv */
// Self-checking bench for the LIN protocol controller in slave mode.
`timescale 1ns/10ps

module lin_protocol_controller_tb;
	localparam int unsigned MS = 10;
	localparam int IDLE = lin_ctrl_pkg::IDLE_S_0 * 1000 * MS;
	logic ref_clk, rst, ce, rxd, txd, wr, rd, irq, node_tx, rxd_prev;
	logic [3:0] addr, n;
	logic [7:0] wdata, rdata, got, pid, ck;
	logic [7:0] data_b [8];
	logic [3:0] len_t [4] = '{4'h2, 4'hF, 4'hF, 4'h1};
	logic [5:0] id_t [4] = '{6'h05, 6'h25, 6'h35, 6'h0A};
	int miscompares, checks_done, seed, idle_cnt;

	// The line is wired-AND with a pull-up.
	assign rxd = node_tx & txd;

	lin_protocol_controller #(.MS_CYCLES(MS)) lin_protocol_controller_i (
		.ref_clk(ref_clk), .rst(rst), .ce(ce), .rxd(rxd), .txd(txd),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq)
	);
	lin_node_model lin_node_model_i (.ref_clk(ref_clk), .tx(node_tx));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		rxd_prev <= rxd;
		idle_cnt <= (rxd !== rxd_prev) ? 0 : idle_cnt + 1;
	end

	// ==========================================================
	// Helpers
	function automatic logic [7:0] par_id(input logic [5:0] id);
		par_id = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), ^{id[0], id[1], id[2], id[4]}, id};
	endfunction : par_id

	function automatic logic [3:0] nbytes(input logic [3:0] l, input logic [5:0] id);
		nbytes = (l != 4'hF) ? l : (id[5] ? (id[4] ? 4'h8 : 4'h4) : 4'h2);
	endfunction : nbytes

	function automatic logic [7:0] csum(input logic [7:0] s, input logic [3:0] k);
		logic [8:0] t;
		t = {1'b0, s};
		for (int i = 0; i < k; i++) begin
			t = {1'b0, t[7:0]} + {1'b0, data_b[i]};
			t = {1'b0, t[7:0]} + {8'h00, t[8]};
		end
		csum = ~t[7:0];
	endfunction : csum

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask : chk8

	task automatic rchk(input string w, input logic [3:0] a,
		input logic [7:0] m, input logic [7:0] e);
		@(posedge ref_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 got = rdata;
		chk8(w, e, got & m);
	endtask : rchk

	task automatic wait_irq(input int lim);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < lim) begin
			@(posedge ref_clk);
			#1 k++;
		end
		chk8("irq", 8'h01, {7'h00, irq});
	endtask : wait_irq

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (95000) @(posedge ref_clk);
		miscompares++;
		report_and_stop();
	end

	// ==========================================================
	// Scenarios
	initial begin
		seed = 32'he892;
		{rst, ce, wr, rd, addr, wdata, idle_cnt} = {2'b11, 14'h0000, 32'h0};
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rchk("div", lin_ctrl_pkg::OFF_DIV_LO, 8'hFF, 8'hC8);
		rchk("timing", lin_ctrl_pkg::OFF_TIMING, 8'hFF, 8'h00);
		rchk("sel", lin_ctrl_pkg::OFF_BUS_TIMING, 8'h0F, 8'h00);
		for (int i = 0; i < 5; i++) begin
			ck = (i == 4) ? 8'h00 : 8'($random(seed) & 32'h0000_000F);
			wr_reg(lin_ctrl_pkg::OFF_BUS_TIMING, ck);
			rchk("sel", lin_ctrl_pkg::OFF_BUS_TIMING, 8'h0F, ck);
		end
		ce <= 1'b0;
		wr_reg(lin_ctrl_pkg::OFF_BUS_TIMING, 8'h05);
		ce <= 1'b1;
		rchk("frozen", lin_ctrl_pkg::OFF_BUS_TIMING, 8'h0F, 8'h00);
		wr_reg(lin_ctrl_pkg::OFF_DIV_LO, 8'h64);
		pid = par_id(6'h12);
		lin_node_model_i.header(pid);
		wait_irq(3000);
		rchk("hdr", lin_ctrl_pkg::OFF_STATUS, 8'h20, 8'h20);
		wr_reg(lin_ctrl_pkg::OFF_CTRL, 8'h84);
		lin_node_model_i.send(8'h3C);
		lin_node_model_i.send(8'hC3);
		chk8("stopped", 8'h00, {7'h00, irq});
		for (int f = 0; f < 4; f++) begin
			pid = par_id(id_t[f]);
			n = nbytes(len_t[f], id_t[f]);
			lin_node_model_i.header(pid);
			wait_irq(3000);
			rchk("id", lin_ctrl_pkg::OFF_ID, 8'hFF, pid);
			wr_reg(lin_ctrl_pkg::OFF_LENGTH, {f[0], 3'h0, len_t[f]});
			wr_reg(lin_ctrl_pkg::OFF_CTRL, 8'h1C);
			for (int i = 0; i < n; i++) begin
				data_b[i] = 8'($random(seed));
				lin_node_model_i.send(data_b[i]);
			end
			ck = csum(f[0] ? pid : 8'h00, n);
			lin_node_model_i.send(ck ^ {7'h00, f == 3});
			wait_irq(300);
			rchk("done", lin_ctrl_pkg::OFF_STATUS, 8'h05, (f == 3) ? 8'h04 : 8'h01);
			rchk("err", lin_ctrl_pkg::OFF_ERROR, 8'h0F, (f == 3) ? 8'h02 : 8'h00);
			for (int i = 0; i < n && f < 3; i++) begin
				rchk("data", i[3:0], 8'hFF, data_b[i]);
			end
			wr_reg(lin_ctrl_pkg::OFF_CTRL, 8'h0C);
		end
		rchk("cleared", lin_ctrl_pkg::OFF_STATUS, 8'h0D, 8'h00);
		wr_reg(lin_ctrl_pkg::OFF_CTRL, 8'h40);
		lin_node_model_i.hold(1'b0, 2);
		lin_node_model_i.hold(1'b1, 1);
		wait_irq(300);
		rchk("wake", lin_ctrl_pkg::OFF_STATUS, 8'h03, 8'h02);
		wr_reg(lin_ctrl_pkg::OFF_CTRL, 8'h04);
		// One short pulse restarts the idle count once sleep is clear.
		lin_node_model_i.hold(1'b0, 1);
		lin_node_model_i.hold(1'b1, 1);
		wait_irq(IDLE + 100);
		chk8("idle", 8'h01, {7'h00, idle_cnt > IDLE - 30 && idle_cnt < IDLE + 60});
		rchk("asleep", lin_ctrl_pkg::OFF_STATUS, 8'h90, 8'h90);
		wr_reg(lin_ctrl_pkg::OFF_CTRL, 8'h06);
		repeat (2) @(posedge ref_clk);
		#1 chk8("txd", 8'h00, {7'h00, txd});
		wait_irq(2100);
		rchk("wk_err", lin_ctrl_pkg::OFF_ERROR, 8'h04, 8'h04);
		rchk("wk_flag", lin_ctrl_pkg::OFF_STATUS, 8'h02, 8'h02);
		report_and_stop();
	end
endmodule : lin_protocol_controller_tb
